// File: hw/wdp_pkg.sv
package wdp_pkg;

  // Clock rate and the nominal rate of the low-frequency oscillator.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LFO_HZ = 31_000;
  // One oscillator tick per this many bus clocks, rounded down to keep it nominal.
  localparam int unsigned LFO_TICK_CYC = CLK_HZ / LFO_HZ;
  localparam logic [9:0] LFO_TICK_LAST = 10'(LFO_TICK_CYC - 1);

  // Register indices and byte addresses (byte address is four times the index).
  localparam logic [9:0] IDX_CTRL = 10'h018;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
  localparam logic [11:0] ADDR_STATE = 12'h300;
  localparam logic [11:0] ADDR_CMD = 12'h304;
  localparam logic [11:0] ADDR_IRQ_STS = 12'h308;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h30C;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Field positions.
  localparam int unsigned OPT_PSA_BIT = 3;
  localparam int unsigned CMD_CLEAR_BIT = 0;
  localparam int unsigned CMD_SLEEP_BIT = 1;
  localparam int unsigned IRQ_RESET_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT = 1;

  // Highest legal period select code and the smallest prescale ratio.
  localparam logic [3:0] PS_MAX_CODE = 4'hB;
  localparam logic [16:0] PRESCALE_MIN = 17'h00020;

  // Watchdog control register layout.
  typedef struct packed {
    logic [2:0] unused;
    logic [3:0] period_select;
    logic software_wd_enable;
  } wdp_ctrl_t;

  // Timeout events leaving the block.
  typedef struct packed {
    logic timeout_wake;
    logic timeout_reset;
  } wdp_evt_t;

  // Watchdog states, Gray coded along off, run, sleep, hold.
  typedef enum logic [1:0] {
    WDP_OFF = 2'b00,
    WDP_RUN = 2'b01,
    WDP_SLEEP = 2'b11,
    WDP_HOLD = 2'b10
  } wdp_state_t;

endpackage

// File: hw/wdp_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Time base is the 31 kHz low-frequency oscillator tick, not its ready flag.
// [RQ2] Control register resets to 0x08: period code 0100, software enable off.
// [RQ3] Oscillator start-up timer running holds the watchdog in reset; resumes afterwards.
// [RQ4] Sixteen-bit prescaler divides oscillator ticks by 32 up to 65536.
// [RQ5] Watchdog prescaler is separate from the timer zero prescale select; option bits 2-0 also postscale the watchdog when option bit 3 is set.
// [RQ6] Configuration enable set keeps watchdog running regardless of software enable.
// [RQ7] With configuration enable clear, control bit 0 starts and stops watchdog.
// [RQ8] Period select bits 4-1 double the ratio; codes above 1011 reserved.
// [RQ9] Count clears when disabled, on clear command, oscillator failure, non-crystal wake.
// [RQ10] Crystal clock wake keeps count cleared until start-up timer finishes.
// [RQ11] Control bits 7-5 read zero and ignore writes.
// [RQ12] Sleep command clears the count but leaves the watchdog running.
// [RQ13] Timeout during sleep wakes the device and clears timeout status.
// [RQ14] Timeout outside sleep resets the device, clears status, restarts from zero.
module wdp_top (
  input wire logic hclk, // Bus clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Always OKAY.
  input wire logic config_wd_enable, // Configuration word enable.
  input wire logic osc_fail, // Oscillator failure pulse.
  input wire logic osc_startup_running, // Start-up timer counting.
  input wire logic sleep_exit, // Wake from another source.
  input wire logic crystal_clock, // System clock is crystal type.
  output logic wd_reset, // Device reset pulse.
  output logic wd_wake, // Wake from sleep pulse.
  output logic timeout_status, // Timeout status, low after timeout.
  output logic [2:0] timer_prescale_select, // Timer zero prescale select.
  output logic prescaler_assign, // Timer zero prescaler assignment.
  output logic irq // Interrupt request.
);
  import wdp_pkg::*;

  // Compare the latched offset against a register address.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Last prescaler count for a period code; reserved codes use the longest ratio.
  function automatic logic [15:0] pre_term(input logic [3:0] code);
    logic [16:0] r;
    r = 17'h00000;
    if (code > PS_MAX_CODE) begin
      r = 17'h0FFFF;
    end else begin
      r = (PRESCALE_MIN << code) - 17'h00001;
    end
    return r[15:0];
  endfunction

  logic acc;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  wdp_ctrl_t ctrl_q;
  logic [7:0] option_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_sts_q;
  logic irq_q;
  logic wr_ctrl;
  logic wr_cmd;
  logic clr_instr;
  logic sleep_cmd;
  logic [9:0] tick_cnt_q;
  logic lfo_tick;
  logic [15:0] pre_cnt_q;
  logic [6:0] post_cnt_q;
  logic [6:0] post_term;
  logic counting;
  logic timeout;
  logic wake_evt;
  logic count_clear;
  logic en;
  logic ost_seen_q;
  wdp_state_t state_q;
  wdp_state_t state_d;
  wdp_evt_t evt_q;
  logic timeout_status_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Address phase is taken only when the bus is ready, so stalled phases never repeat.
  assign acc = hsel & htrans[1] & hready;
  assign wr_ctrl = wr_pend_q & hit(addr_q, ADDR_CTRL);
  assign wr_cmd = wr_pend_q & hit(addr_q, ADDR_CMD);
  assign clr_instr = wr_cmd & hwdata[CMD_CLEAR_BIT];
  assign sleep_cmd = wr_cmd & hwdata[CMD_SLEEP_BIT];

  // Latch the address phase; reads get one wait state so a preceding write is visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= acc & hwrite;
      rd_pend_q <= acc & ~hwrite;
      hreadyout_q <= ~(acc & ~hwrite);
      if (acc) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  // Read multiplexer; unmapped offsets and the command register read as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(addr_q, ADDR_CTRL)) begin
      rd_mux = {24'h000000, 3'h0, ctrl_q.period_select, ctrl_q.software_wd_enable}; // RQ11
    end else if (hit(addr_q, ADDR_OPTION)) begin
      rd_mux = {24'h000000, option_q};
    end else if (hit(addr_q, ADDR_STATE)) begin
      rd_mux = {27'h0000000, timeout_status_q, ost_seen_q, state_q, en};
    end else if (hit(addr_q, ADDR_IRQ_STS)) begin
      rd_mux = {30'h00000000, irq_sts_q};
    end else if (hit(addr_q, ADDR_IRQ_MASK)) begin
      rd_mux = {30'h00000000, irq_mask_q};
    end
  end

  // Read data is captured in the wait cycle and stands until the next read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // Control and option registers; the unused control bits are never stored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET; // RQ2
      option_q <= OPTION_RESET;
      irq_mask_q <= IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {3'h0, hwdata[4:0]}; // RQ11
      end
      if (wr_pend_q & hit(addr_q, ADDR_OPTION)) begin
        option_q <= hwdata[7:0];
      end
      if (wr_pend_q & hit(addr_q, ADDR_IRQ_MASK)) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  // Free-running oscillator tick; the oscillator itself never stops for the watchdog.
  assign lfo_tick = tick_cnt_q == LFO_TICK_LAST; // RQ1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 10'h000;
    end else if (lfo_tick) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end

  // Either enable runs the watchdog; the configuration bit overrides software.
  assign en = config_wd_enable | ctrl_q.software_wd_enable; // RQ6 RQ7

  // Postscale from the option bits only when the prescaler is assigned to the watchdog.
  assign post_term = option_q[OPT_PSA_BIT] ?
                     7'((8'h01 << option_q[2:0]) - 8'h01) : 7'h00; // RQ5
  // A running start-up timer borrows the counter, so it stops counting in that very cycle.
  assign counting = ((state_q == WDP_RUN) | (state_q == WDP_SLEEP)) & ~osc_startup_running; // RQ3
  assign timeout = counting & lfo_tick & (pre_cnt_q >= pre_term(ctrl_q.period_select)) &
                   (post_cnt_q >= post_term); // RQ8
  assign wake_evt = (state_q == WDP_SLEEP) & (timeout | sleep_exit);
  // Any clear source, or a state that is not counting, zeroes both stages.
  assign count_clear = ~counting | clr_instr | osc_fail | sleep_cmd | wake_evt; // RQ9 RQ12

  // Sequencing of off, run, sleep and the start-up hold.
  always_comb begin
    state_d = state_q;
    if (osc_startup_running) begin
      state_d = WDP_HOLD; // RQ3
    end else begin
      unique case (state_q)
        WDP_OFF: begin
          if (en) begin
            state_d = WDP_RUN;
          end
        end
        WDP_RUN: begin
          if (!en) begin
            state_d = WDP_OFF;
          end else if (sleep_cmd) begin
            state_d = WDP_SLEEP; // RQ12
          end
        end
        WDP_SLEEP: begin
          if (wake_evt) begin
            state_d = crystal_clock ? WDP_HOLD : (en ? WDP_RUN : WDP_OFF); // RQ10
          end else if (!en) begin
            state_d = WDP_OFF;
          end
        end
        WDP_HOLD: begin
          if (ost_seen_q) begin
            state_d = en ? WDP_RUN : WDP_OFF; // RQ3
          end
        end
      endcase
    end
  end

  // A crystal wake waits for the start-up timer to have run and then finished.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= WDP_OFF;
      ost_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ost_seen_q <= (state_d == WDP_HOLD) & (ost_seen_q | osc_startup_running); // RQ10
    end
  end

  // Prescaler then postscaler; both wrap to zero at terminal count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_q <= 16'h0000;
      post_cnt_q <= 7'h00;
    end else if (count_clear) begin
      pre_cnt_q <= 16'h0000; // RQ9
      post_cnt_q <= 7'h00;
    end else if (lfo_tick) begin
      if (pre_cnt_q >= pre_term(ctrl_q.period_select)) begin
        pre_cnt_q <= 16'h0000; // RQ4 RQ14
        post_cnt_q <= (post_cnt_q >= post_term) ? 7'h00 : post_cnt_q + 7'h01;
      end else begin
        pre_cnt_q <= pre_cnt_q + 16'h0001;
      end
    end
  end

  // Timeout outputs; status drops on timeout, rises again on clear or sleep.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= '0;
      timeout_status_q <= 1'b1;
    end else begin
      evt_q.timeout_reset <= timeout & (state_q == WDP_RUN); // RQ14
      evt_q.timeout_wake <= timeout & (state_q == WDP_SLEEP); // RQ13
      if (timeout) begin
        timeout_status_q <= 1'b0; // RQ13 RQ14
      end else if (clr_instr | sleep_cmd) begin
        timeout_status_q <= 1'b1;
      end
    end
  end

  // Sticky event bits: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_q <= IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~((wr_pend_q & hit(addr_q, ADDR_IRQ_STS)) ? hwdata[1:0] : 2'h0))
                   | {evt_q.timeout_wake, evt_q.timeout_reset};
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign wd_reset = evt_q.timeout_reset;
  assign wd_wake = evt_q.timeout_wake;
  assign timeout_status = timeout_status_q;
  assign timer_prescale_select = option_q[2:0];
  assign prescaler_assign = option_q[OPT_PSA_BIT];
  assign irq = irq_q;

  sequence s_sw_off_write;
    wr_ctrl && !hwdata[0] && !config_wd_enable && !osc_startup_running;
  endsequence

  sequence s_stay_quiet;
    !osc_startup_running && !config_wd_enable;
  endsequence

  property p_lfo_spacing;
    lfo_tick |=> !lfo_tick [*8];
  endproperty
  a_lfo_spacing: assert property (p_lfo_spacing) else $error("tick too soon"); // RQ1

  property p_ctrl_reset;
    $rose(hresetn) |-> ctrl_q == CTRL_RESET;
  endproperty
  a_ctrl_reset: assert property (@(posedge hclk) p_ctrl_reset) // RQ2
    else $error("control reset value wrong");

  property p_hold_ost;
    osc_startup_running |=> state_q == WDP_HOLD && pre_cnt_q == 16'h0000;
  endproperty
  a_hold_ost: assert property (p_hold_ost) else $error("not held during start-up"); // RQ3

  property p_cfg_runs;
    config_wd_enable && !osc_startup_running && state_q == WDP_OFF |=> state_q == WDP_RUN;
  endproperty
  a_cfg_runs: assert property (p_cfg_runs) else $error("config enable ignored"); // RQ6

  property p_sw_off;
    s_sw_off_write ##1 s_stay_quiet |=> state_q == WDP_OFF || state_q == WDP_HOLD;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("software disable ignored"); // RQ7

  property p_clear_cmd;
    clr_instr || osc_fail |=> pre_cnt_q == 16'h0000 && post_cnt_q == 7'h00;
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("count not cleared"); // RQ9

  property p_ctrl_unused;
    rd_pend_q && hit(addr_q, ADDR_CTRL) |=> hrdata_q[31:5] == 27'h0000000;
  endproperty
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bits read one"); // RQ11

  property p_sleep_enter;
    state_q == WDP_RUN && en && sleep_cmd && !osc_startup_running
      |=> state_q == WDP_SLEEP && pre_cnt_q == 16'h0000;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry wrong"); // RQ12

  property p_wake;
    timeout && state_q == WDP_SLEEP |=> wd_wake && !wd_reset && !timeout_status ##1 !wd_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("timeout in sleep did not wake"); // RQ13

  property p_reset_out;
    timeout && state_q == WDP_RUN |=> wd_reset && !timeout_status && pre_cnt_q == 16'h0000;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("timeout did not reset"); // RQ14

  property p_crystal_wake;
    state_q == WDP_SLEEP && sleep_exit && crystal_clock |=> state_q == WDP_HOLD;
  endproperty
  a_crystal_wake: assert property (p_crystal_wake) else $error("crystal wake not held"); // RQ10

endmodule
`default_nettype wire

// File: tb/wdp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wdp_top_tb;
  import wdp_pkg::*;
  // One period at the smallest prescale ratio without postscale, in bus clocks.
  localparam int PER = LFO_TICK_CYC * 32;
  logic hclk, hresetn, hsel, hwrite, config_wd_enable, osc_fail, osc_startup_running;
  logic sleep_exit, crystal_clock, hreadyout, hresp, wd_reset, wd_wake, timeout_status;
  logic prescaler_assign, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, seen;
  logic [2:0] timer_prescale_select;
  int error_cnt = 0;
  int checked = 0;
  int n;

  wdp_top wdp_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .config_wd_enable(config_wd_enable), .osc_fail(osc_fail),
    .osc_startup_running(osc_startup_running), .sleep_exit(sleep_exit),
    .crystal_clock(crystal_clock), .wd_reset(wd_reset), .wd_wake(wd_wake),
    .timeout_status(timeout_status), .timer_prescale_select(timer_prescale_select),
    .prescaler_assign(prescaler_assign), .irq(irq)
  );

  // Free-running bus clock, 50 ns period.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on the slave's ready, so no fixed latency is assumed.
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Raises one strobe for len clocks: 0 oscillator fail, 1 sleep exit, 2 start-up timer.
  task automatic pulse(input int which, input int len);
    @(posedge hclk);
    if (which == 0) osc_fail <= 1'b1;
    else if (which == 1) sleep_exit <= 1'b1;
    else osc_startup_running <= 1'b1;
    repeat (len) @(posedge hclk);
    osc_fail <= 1'b0;
    sleep_exit <= 1'b0;
    osc_startup_running <= 1'b0;
  endtask

  // Counts clocks until a timeout event; the bound keeps a dead counter from hanging.
  task automatic wait_to();
    n = 0;
    seen = 2'b00;
    while (seen == 2'b00 && n < PER + 2000) begin
      @(posedge hclk);
      n++;
      seen = {wd_wake, wd_reset};
    end
  endtask

  task automatic t_reset_values();
    ahb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0000_0008);
    ahb(1'b0, ADDR_OPTION, 32'h0); chk(rd, 32'h0000_00FF);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h0);
    chk(timeout_status, 1'b1);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
    $display("Test reset_values done");
  endtask

  task automatic t_reg_bits();
    ahb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
    ahb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0000_001F);
    ahb(1'b0, 12'h3F0, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h0000_0018);
    ahb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0000_0018);
    ahb(1'b1, ADDR_CTRL, 32'h0000_0008);
    $display("Test reg_bits done");
  endtask

  task automatic t_enables();
    ahb(1'b1, ADDR_CTRL, 32'h0000_0009);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h3);
    ahb(1'b1, ADDR_CTRL, 32'h0000_0008);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h0);
    config_wd_enable <= 1'b1;
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h3);
    config_wd_enable <= 1'b0;
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h0);
    $display("Test enables done");
  endtask

  task automatic t_hold();
    ahb(1'b1, ADDR_CTRL, 32'h0000_0009);
    osc_startup_running <= 1'b1;
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:1], 2'h2);
    osc_startup_running <= 1'b0;
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h3);
    $display("Test hold done");
  endtask

  // Timer zero prescale is set to show it leaves the watchdog ratio alone.
  task automatic t_timeout();
    ahb(1'b1, ADDR_OPTION, 32'h0000_0005);
    @(posedge hclk);
    chk(timer_prescale_select, 3'h5);
    chk(prescaler_assign, 1'b0);
    ahb(1'b1, ADDR_CTRL, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (5000) @(posedge hclk);
    pulse(0, 1);
    wait_to();
    chk(seen, 2'h1);
    chk(32'(n >= PER - 700 && n <= PER + 700), 32'h1);
    repeat (3) @(posedge hclk);
    chk(timeout_status, 1'b0);
    ahb(1'b0, ADDR_IRQ_STS, 32'h0); chk(rd[1:0], 2'h1);
    chk(irq, 1'b0);
    ahb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    ahb(1'b1, ADDR_IRQ_STS, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    repeat (5000) @(posedge hclk);
    ahb(1'b1, ADDR_CMD, 32'h0000_0001);
    @(posedge hclk);
    chk(timeout_status, 1'b1);
    wait_to();
    chk(seen, 2'h1);
    chk(32'(n >= PER - 700 && n <= PER + 700), 32'h1);
    $display("Test timeout done");
  endtask

  task automatic t_sleep();
    ahb(1'b1, ADDR_CMD, 32'h0000_0002);
    @(posedge hclk);
    chk(timeout_status, 1'b1);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h7);
    wait_to();
    chk(seen, 2'h2);
    chk(32'(n >= PER - 700 && n <= PER + 700), 32'h1);
    repeat (2) @(posedge hclk);
    chk(timeout_status, 1'b0);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h3);
    crystal_clock <= 1'b1;
    ahb(1'b1, ADDR_CMD, 32'h0000_0002);
    pulse(1, 1);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:1], 2'h2);
    pulse(2, 3);
    repeat (3) @(posedge hclk);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h3);
    $display("Test sleep done");
  endtask

  // A reset in mid-run must bring the control register back to its reset pattern.
  task automatic t_rereset();
    ahb(1'b1, ADDR_CTRL, 32'h0000_001F);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0000_0008);
    ahb(1'b0, ADDR_STATE, 32'h0); chk(rd[2:0], 3'h0);
    chk(timeout_status, 1'b1);
    $display("Test rereset done");
  endtask

  // Main sequence: every input gets a value at time zero, reset for 8 clocks.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    config_wd_enable = 1'b0;
    osc_fail = 1'b0;
    osc_startup_running = 1'b0;
    sleep_exit = 1'b0;
    crystal_clock = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_reg_bits();
    t_enables();
    t_hold();
    t_timeout();
    t_sleep();
    t_rereset();
    wrap_up();
  end

  // Guard against a hang; the tests need roughly 75000 clocks.
  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    $display("Watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
